//--- rtl/smmc_pkg.sv
package smmc_pkg;

  // ------------------------------------------------------------------
  // sizes and counts
  // ------------------------------------------------------------------
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned BIT_CNT_W = 3;
  localparam logic [2:0]  LAST_BIT  = 3'h7;
  localparam logic [2:0]  FIRST_BIT = 3'h0;

  // ------------------------------------------------------------------
  // control register layout, msb first:
  // 7 done, 6 master enable, 5 mode fault, 4 reserved (reads 0),
  // 3 select mode hi, 2 select mode lo, 1 tx buffer empty, 0 port enable
  // ------------------------------------------------------------------
  typedef struct packed {
    logic transfer_done_flag;
    logic master_enable_bit;
    logic mode_fault_flag;
    logic rsvd;
    logic select_mode_hi_bit;
    logic select_mode_lo_bit;
    logic tx_buf_empty;
    logic port_enable_bit;
  } smmc_ctrl_t;

  // multi-master default, buffer empty
  localparam logic [7:0] CTRL_RESET = 8'h06;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // ------------------------------------------------------------------
  // link side
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    SMMC_IDLE = 3'h1,
    SMMC_LOW  = 3'h2,
    SMMC_HIGH = 3'h4
  } smmc_state_t;

  typedef struct packed {
    logic sck;
    logic mosi;
  } smmc_link_t;

  typedef struct packed {
    logic drv;
    logic oe;
    logic pin_req;
  } smmc_sel_t;

endpackage

//--- rtl/smmc_sync.sv
`timescale 1ns/100ps
module smmc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // clock, reset and enable
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic en_in,
  // level to cross
  input  wire logic d_in,
  output logic      q_out
);

  // ------------------------------------------------------------------
  // two-stage synchroniser
  // ------------------------------------------------------------------
  // first stage is read only by the second stage
  logic meta_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= RST_VAL;
      q_out  <= RST_VAL;
    end else if (en_in) begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end

endmodule

//--- rtl/smmc_top.sv
`timescale 1ns/100ps
module smmc_top (
  // system clock, reset, enable
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_in,
  input  wire logic                 ce_in,
  // link clock
  input  wire logic                 clk_link_in,
  // software data access
  input  wire logic                 sw_data_wr_in,
  input  wire logic [7:0]           sw_data_in,
  output logic      [7:0]           port_data_reg_out,
  // software control access
  input  wire logic                 sw_ctrl_wr_in,
  input  wire logic [7:0]           sw_ctrl_in,
  output smmc_pkg::smmc_ctrl_t      port_control_reg_out,
  // interrupt
  input  wire logic                 irq_en_in,
  output logic                      irq_out,
  // serial link
  output logic                      sck_out,
  output logic                      mosi_out,
  input  wire logic                 miso_in,
  // slave select
  input  wire logic                 nss_in,
  output logic                      nss_out,
  output logic                      nss_oe_out,
  output logic                      nss_pin_req_out
);

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  smmc_pkg::smmc_ctrl_t  ctrl_r;
  smmc_pkg::smmc_ctrl_t  ctrl_nxt;
  smmc_pkg::smmc_ctrl_t  ctrl_wr;
  smmc_pkg::smmc_sel_t   sel_r;
  smmc_pkg::smmc_sel_t   sel_nxt;
  smmc_pkg::smmc_link_t  link_r;
  smmc_pkg::smmc_link_t  link_nxt;
  smmc_pkg::smmc_state_t state_r;
  smmc_pkg::smmc_state_t state_nxt;

  logic [7:0]            tx_buf_r;
  logic [7:0]            tx_hold_r;
  logic                  tx_full_r;
  logic                  busy_r;
  logic                  req_tgl_r;
  logic                  ack_seen_r;
  logic [7:0]            rx_buf_r;
  logic                  irq_r;

  logic                  nss_sync;
  logic                  ack_sync;
  logic                  req_sync;
  logic                  ce_link;

  logic [7:0]            shift_r;
  logic [7:0]            shift_nxt;
  logic [2:0]            bit_cnt_r;
  logic [2:0]            bit_cnt_nxt;
  logic                  miso_bit_r;
  logic                  miso_bit_nxt;
  logic                  req_seen_r;
  logic                  ack_tgl_r;
  logic                  ack_tgl_nxt;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // a flag set by hardware survives a clearing write in the same cycle
  function automatic logic flag_next(input logic cur,
                                     input logic wr,
                                     input logic wval,
                                     input logic set);
    logic v;
    v = cur;
    if (wr) begin
      v = wval;
    end
    flag_next = v | set;
  endfunction

  function automatic logic [2:0] bump(input logic [2:0] cnt);
    bump = 3'(cnt + 3'h1);
  endfunction

  // ------------------------------------------------------------------
  // crossings
  // ------------------------------------------------------------------
  // select pin is asynchronous, sits high when nobody drives it
  smmc_sync #(.RST_VAL(1'b1)) u_nss_sync (
    .clk_in (clk_sys_in),
    .rst_in (rst_in),
    .en_in  (ce_in),
    .d_in   (nss_in),
    .q_out  (nss_sync)
  );

  smmc_sync #(.RST_VAL(1'b0)) u_ack_sync (
    .clk_in (clk_sys_in),
    .rst_in (rst_in),
    .en_in  (ce_in),
    .d_in   (ack_tgl_r),
    .q_out  (ack_sync)
  );

  smmc_sync #(.RST_VAL(1'b0)) u_req_sync (
    .clk_in (clk_link_in),
    .rst_in (rst_in),
    .en_in  (1'b1),
    .d_in   (req_tgl_r),
    .q_out  (req_sync)
  );

  // enable itself must keep crossing, so its synchroniser runs free
  smmc_sync #(.RST_VAL(1'b0)) u_ce_sync (
    .clk_in (clk_link_in),
    .rst_in (rst_in),
    .en_in  (1'b1),
    .d_in   (ce_in),
    .q_out  (ce_link)
  );

  // ------------------------------------------------------------------
  // system side decode
  // ------------------------------------------------------------------
  wire   multi_mode    = ~ctrl_r.select_mode_hi_bit & ctrl_r.select_mode_lo_bit;
  wire   three_wire    = ~ctrl_r.select_mode_hi_bit & ~ctrl_r.select_mode_lo_bit;
  wire   four_wire     = ctrl_r.select_mode_hi_bit;
  wire   is_master     = ctrl_r.master_enable_bit & ctrl_r.port_enable_bit;
  // fault only while master enable is set (port enable not needed) and only in multi-master mode
  wire   mode_fault    = multi_mode & ~nss_sync & ctrl_r.master_enable_bit;
  wire   ack_evt       = ack_sync ^ ack_seen_r;
  wire   xfer_done     = ack_evt & busy_r;
  // shifter is free once the previous answer came back
  wire   start_xfer    = tx_full_r & ~busy_r & is_master & ~mode_fault;
  wire   wr_buf        = sw_data_wr_in & ctrl_r.master_enable_bit;

  // ------------------------------------------------------------------
  // status and interrupt next values
  // ------------------------------------------------------------------
  // a buffered byte stays held unless it leaves for the shifter now
  wire   buf_held      = (tx_full_r & ~start_xfer) | wr_buf;
  // level interrupt: either sticky flag keeps it asserted
  wire   irq_nxt       = irq_en_in &
                         (ctrl_r.transfer_done_flag | ctrl_r.mode_fault_flag);

  assign ctrl_wr = smmc_pkg::smmc_ctrl_t'(sw_ctrl_in);

  // ------------------------------------------------------------------
  // control register next value
  // ------------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (sw_ctrl_wr_in) begin
      ctrl_nxt.master_enable_bit  = ctrl_wr.master_enable_bit;
      ctrl_nxt.port_enable_bit    = ctrl_wr.port_enable_bit;
      ctrl_nxt.select_mode_hi_bit = ctrl_wr.select_mode_hi_bit;
      ctrl_nxt.select_mode_lo_bit = ctrl_wr.select_mode_lo_bit;
    end
    ctrl_nxt.transfer_done_flag = flag_next(ctrl_r.transfer_done_flag, sw_ctrl_wr_in,
                                            ctrl_wr.transfer_done_flag, xfer_done);
    ctrl_nxt.mode_fault_flag    = flag_next(ctrl_r.mode_fault_flag, sw_ctrl_wr_in,
                                            ctrl_wr.mode_fault_flag, mode_fault);
    // fault wins over a simultaneous enabling write; only software re-enables
    if (mode_fault) begin
      ctrl_nxt.master_enable_bit = 1'b0;
      ctrl_nxt.port_enable_bit   = 1'b0;
    end
    ctrl_nxt.rsvd         = 1'b0;
    ctrl_nxt.tx_buf_empty = ~buf_held;
  end

  // ------------------------------------------------------------------
  // slave select pin control
  // ------------------------------------------------------------------
  always_comb begin
    sel_nxt.drv     = ctrl_r.select_mode_lo_bit;
    sel_nxt.oe      = four_wire;
    // 3-wire leaves the pin to the crossbar for other use
    sel_nxt.pin_req = ~three_wire;
  end

  // ------------------------------------------------------------------
  // system side registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_r <= smmc_pkg::smmc_ctrl_t'(smmc_pkg::CTRL_RESET);
      sel_r  <= '0;
      irq_r  <= 1'b0;
    end else if (ce_in) begin
      ctrl_r <= ctrl_nxt;
      sel_r  <= sel_nxt;
      irq_r  <= irq_nxt;
    end
  end

  // a second write before the shifter frees simply replaces the byte
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      tx_buf_r  <= smmc_pkg::DATA_RESET;
      tx_full_r <= 1'b0;
    end else if (ce_in) begin
      if (wr_buf) begin
        tx_buf_r  <= sw_data_in;
        tx_full_r <= 1'b1;
      end else if (start_xfer) begin
        tx_full_r <= 1'b0;
      end
    end
  end

  // word crossing: tx_hold_r is stable from the toggle until the answer
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      tx_hold_r <= smmc_pkg::DATA_RESET;
      req_tgl_r <= 1'b0;
      busy_r    <= 1'b0;
    end else if (ce_in) begin
      if (start_xfer) begin
        tx_hold_r <= tx_buf_r;
        req_tgl_r <= ~req_tgl_r;
        busy_r    <= 1'b1;
      end else if (xfer_done) begin
        busy_r    <= 1'b0;
      end
    end
  end

  // shift_r is idle and stable once the answer toggle has crossed
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ack_seen_r <= 1'b0;
      rx_buf_r   <= smmc_pkg::DATA_RESET;
    end else if (ce_in) begin
      ack_seen_r <= ack_sync;
      if (xfer_done) begin
        rx_buf_r <= shift_r;
      end
    end
  end

  // ------------------------------------------------------------------
  // link side shifter
  // ------------------------------------------------------------------
  // sck runs at half the link clock; mode 0: slave samples on rise
  // limitation: clock phase, polarity and rate are fixed
  wire   new_req   = req_sync ^ req_seen_r;
  wire   link_idle = (state_r == smmc_pkg::SMMC_IDLE);
  wire   last_bit  = (bit_cnt_r == smmc_pkg::LAST_BIT);

  always_comb begin
    state_nxt    = state_r;
    link_nxt     = link_r;
    shift_nxt    = shift_r;
    bit_cnt_nxt  = bit_cnt_r;
    miso_bit_nxt = miso_bit_r;
    ack_tgl_nxt  = ack_tgl_r;
    case (state_r)
      smmc_pkg::SMMC_IDLE: begin
        link_nxt.sck = 1'b0;
        if (new_req) begin
          shift_nxt     = tx_hold_r;
          link_nxt.mosi = tx_hold_r[7];
          bit_cnt_nxt   = smmc_pkg::FIRST_BIT;
          state_nxt     = smmc_pkg::SMMC_LOW;
        end
      end
      smmc_pkg::SMMC_LOW: begin
        // slave drives miso from our clock, so it is link-synchronous
        link_nxt.sck = 1'b1;
        miso_bit_nxt = miso_in;
        state_nxt    = smmc_pkg::SMMC_HIGH;
      end
      smmc_pkg::SMMC_HIGH: begin
        link_nxt.sck  = 1'b0;
        shift_nxt     = {shift_r[6:0], miso_bit_r};
        link_nxt.mosi = shift_r[6];
        bit_cnt_nxt   = bump(bit_cnt_r);
        if (last_bit) begin
          ack_tgl_nxt = ~ack_tgl_r;
          state_nxt   = smmc_pkg::SMMC_IDLE;
        end else begin
          state_nxt   = smmc_pkg::SMMC_LOW;
        end
      end
      default: begin
        state_nxt = smmc_pkg::SMMC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_link_in or posedge rst_in) begin
    if (rst_in) begin
      state_r    <= smmc_pkg::SMMC_IDLE;
      link_r     <= '0;
      shift_r    <= smmc_pkg::DATA_RESET;
      bit_cnt_r  <= smmc_pkg::FIRST_BIT;
      miso_bit_r <= 1'b0;
    end else if (ce_link) begin
      state_r    <= state_nxt;
      link_r     <= link_nxt;
      shift_r    <= shift_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      miso_bit_r <= miso_bit_nxt;
    end
  end

  always_ff @(posedge clk_link_in or posedge rst_in) begin
    if (rst_in) begin
      req_seen_r <= 1'b0;
      ack_tgl_r  <= 1'b0;
    end else if (ce_link) begin
      if (link_idle) begin
        req_seen_r <= req_sync;
      end
      ack_tgl_r <= ack_tgl_nxt;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // every output is a flop, so pin requests trail the mode by one cycle
  assign port_data_reg_out    = rx_buf_r;
  assign port_control_reg_out = ctrl_r;
  assign irq_out              = irq_r;
  assign sck_out              = link_r.sck;
  assign mosi_out             = link_r.mosi;
  assign nss_out              = sel_r.drv;
  assign nss_oe_out           = sel_r.oe;
  assign nss_pin_req_out      = sel_r.pin_req;

endmodule

//--- tb/smmc_assertions.sv
`timescale 1ns/100ps
module smmc_assertions (
  // clocks and reset
  input wire logic                 clk_sys_in,
  input wire logic                 clk_link_in,
  input wire logic                 rst_in,
  // inputs
  input wire logic                 ce_in,
  input wire logic                 sw_data_wr_in,
  input wire logic                 sw_ctrl_wr_in,
  input wire logic                 irq_en_in,
  input wire logic                 nss_in,
  // outputs
  input wire smmc_pkg::smmc_ctrl_t port_control_reg_out,
  input wire logic                 irq_out,
  input wire logic                 sck_out,
  input wire logic                 mosi_out,
  input wire logic                 nss_out,
  input wire logic                 nss_oe_out,
  input wire logic                 nss_pin_req_out
);
  // ------------------------------
  // control register views
  // ------------------------------
  wire logic [1:0] sel = {port_control_reg_out.select_mode_hi_bit,
                          port_control_reg_out.select_mode_lo_bit};
  wire logic       mst = port_control_reg_out.master_enable_bit;
  wire logic       flt = port_control_reg_out.mode_fault_flag;
  wire logic       dne = port_control_reg_out.transfer_done_flag;
  wire logic       txe = port_control_reg_out.tx_buf_empty;
  wire logic       pen = port_control_reg_out.port_enable_bit;
  // three samples cover the two-stage select synchroniser
  property p_fault;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && !nss_in && mst && sel == 2'h1)[*3] |=> flt && !mst && !pen;
  endproperty
  a_fault: assert property (p_fault) else $error("no fault on low select");
  property p_no_restore;
    @(posedge clk_sys_in) disable iff (rst_in) !sw_ctrl_wr_in && !mst |=> !mst;
  endproperty
  a_no_restore: assert property (p_no_restore) else $error("enable came back");
  property p_only_mm;
    @(posedge clk_sys_in) disable iff (rst_in) !sw_ctrl_wr_in && sel != 2'h1 |=> $stable(mst);
  endproperty
  a_only_mm: assert property (p_only_mm) else $error("enable moved outside mm");
  // pins lag the mode by a cycle, so the reset edge itself is left out
  property p_mm;
    @(posedge clk_sys_in) disable iff (rst_in)
    !$past(rst_in) && sel == 2'h1 |=> nss_pin_req_out && !nss_oe_out;
  endproperty
  a_mm: assert property (p_mm) else $error("select not input");
  property p_3w;
    @(posedge clk_sys_in) disable iff (rst_in) sel == 2'h0 |=> !nss_pin_req_out && !nss_oe_out;
  endproperty
  a_3w: assert property (p_3w) else $error("select pin used in 3-wire");
  property p_4w;
    @(posedge clk_sys_in) disable iff (rst_in)
    sel[1] |=> nss_oe_out && nss_out == $past(sel[0]);
  endproperty
  a_4w: assert property (p_4w) else $error("select output wrong");
  property p_irq;
    @(posedge clk_sys_in) disable iff (rst_in) irq_en_in && (dne || flt) |=> irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  property p_irq_quiet;
    @(posedge clk_sys_in) disable iff (rst_in) !(irq_en_in && (dne || flt)) |=> !irq_out;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq unexpected");
  property p_done_hold;
    @(posedge clk_sys_in) disable iff (rst_in) dne && !sw_ctrl_wr_in |=> dne;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done flag lost");
  property p_txbuf;
    @(posedge clk_sys_in) disable iff (rst_in) ce_in && sw_data_wr_in && mst |=> !txe;
  endproperty
  a_txbuf: assert property (p_txbuf) else $error("write not buffered");
  property p_ignore;
    @(posedge clk_sys_in) disable iff (rst_in) sw_data_wr_in && !mst && txe |=> txe;
  endproperty
  a_ignore: assert property (p_ignore) else $error("write taken when not master");
  // data may only move while the clock is low
  property p_mosi;
    @(posedge clk_link_in) disable iff (rst_in) sck_out |-> $stable(mosi_out);
  endproperty
  a_mosi: assert property (p_mosi) else $error("mosi moved with sck high");
  c_done: cover property (@(posedge clk_sys_in) disable iff (rst_in) $rose(dne));
  c_fault: cover property (@(posedge clk_sys_in) disable iff (rst_in) $rose(flt));
  c_4w: cover property (@(posedge clk_sys_in) disable iff (rst_in) nss_oe_out);
endmodule

bind smmc_top smmc_assertions i_chk (.clk_sys_in, .clk_link_in, .rst_in, .ce_in, .sw_data_wr_in,
  .sw_ctrl_wr_in, .irq_en_in, .nss_in, .port_control_reg_out, .irq_out, .sck_out, .mosi_out,
  .nss_out, .nss_oe_out, .nss_pin_req_out);

//--- tb/smmc_slave_model.sv
`timescale 1ns/100ps
module smmc_slave_model (
  // serial link from the master
  input  wire logic       sck_in,
  input  wire logic       mosi_in,
  // preset reply byte
  input  wire logic       load_in,
  input  wire logic [7:0] tx_in,
  // reply line and captured byte
  output logic            miso_out,
  output logic [7:0]      rx_out
);
  // ------------------------------
  // behavioural slave
  // ------------------------------
  logic [7:0] sh_r = 8'h00;
  int         cnt_r = 0;
  // one process owns every output; sck is idle while load is high
  // a finished byte rearms the same reply, so chained frames get answered
  always @(posedge load_in or posedge sck_in or negedge sck_in) begin
    if (load_in) begin
      sh_r = tx_in;
      cnt_r = 0;
    end else if (sck_in) begin
      rx_out = {rx_out[6:0], mosi_in};
      cnt_r++;
    end else begin
      sh_r = (cnt_r == 8) ? tx_in : {sh_r[6:0], 1'b0};
      if (cnt_r == 8)
        cnt_r = 0;
    end
    miso_out = sh_r[7];
  end
endmodule

//--- tb/test_spi_master_mode_control.sv
`timescale 1ns/100ps
module test_spi_master_mode_control;
  // ------------------------------
  // stimulus and observation
  // ------------------------------
  logic                 clk_sys_in = 1'b0, clk_link_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1;
  logic                 sw_data_wr_in = 1'b0, sw_ctrl_wr_in = 1'b0, irq_en_in = 1'b0;
  logic                 nss_in = 1'b1, sl_load = 1'b0;
  logic [7:0]           sw_data_in = 8'h00, sw_ctrl_in = 8'h00, sl_tx = 8'h00;
  logic [7:0]           port_data_reg_out, sl_rx, v, b, d;
  logic                 irq_out, sck_out, mosi_out, miso_in, nss_out, nss_oe_out;
  logic                 nss_pin_req_out;
  smmc_pkg::smmc_ctrl_t port_control_reg_out;
  wire logic [7:0]      ctl = port_control_reg_out;
  int                   n_fail = 0, compares = 0, k;

  always #50 clk_sys_in = ~clk_sys_in;
  // link clock free running; the offset keeps its edges off the system edges
  initial begin
    #0.5;
    forever #6 clk_link_in = ~clk_link_in;
  end

  smmc_top i_dut (.clk_sys_in, .rst_in, .ce_in, .clk_link_in, .sw_data_wr_in, .sw_data_in,
    .port_data_reg_out, .sw_ctrl_wr_in, .sw_ctrl_in, .port_control_reg_out, .irq_en_in,
    .irq_out, .sck_out, .mosi_out, .miso_in, .nss_in, .nss_out, .nss_oe_out, .nss_pin_req_out);
  smmc_slave_model i_slave (.sck_in(sck_out), .mosi_in(mosi_out), .load_in(sl_load),
    .tx_in(sl_tx), .miso_out(miso_in), .rx_out(sl_rx));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // select pins after a control write: oe, pin request, drive level
  function automatic logic [7:0] sel_pins(input logic [7:0] c);
    sel_pins = {5'h00, c[3], c[3] | c[2], c[2]};
  endfunction
  task automatic give_verdict;
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // a strobe is dropped and one edge passes before the next request
  task automatic ctrl_wr(input logic [7:0] val);
    sw_ctrl_in <= val;
    sw_ctrl_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    sw_ctrl_wr_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic data_wr(input logic [7:0] val);
    sw_data_in <= val;
    sw_data_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    sw_data_wr_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic wait_bit(input int n);
    int i;
    for (i = 0; ctl[n] !== 1'b1; i++) begin
      if (i == 60) begin
        n_fail++;
        give_verdict;
      end
      @(posedge clk_sys_in);
    end
  endtask
  task automatic load_slave(input logic [7:0] val);
    sl_tx <= val;
    sl_load <= 1'b1;
    @(posedge clk_sys_in);
    sl_load <= 1'b0;
  endtask

  initial begin
    void'($urandom(89133));
    repeat (4) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    check(ctl, 8'h06);
    check(port_data_reg_out, 8'h00);
    check({7'h00, irq_out}, 8'h00);
    // cycle through 3-wire, multi-master and 4-wire, select noise outside mm
    for (k = 0; k < 9; k++) begin
      v = (k % 3 == 0) ? 8'h41 : (k % 3 == 1) ? 8'h45 : (8'h49 | (8'($urandom) & 8'h04));
      b = (k < 2) ? {8{k[0]}} : 8'($urandom);
      d = (k < 2) ? ~b : 8'($urandom);
      ctrl_wr(v);
      check(ctl, v | 8'h02);
      irq_en_in <= 1'($urandom);
      nss_in <= (k % 3 == 1) ? 1'b1 : 1'($urandom);
      load_slave(b);
      check({5'h00, nss_oe_out, nss_pin_req_out, nss_out}, sel_pins(v));
      data_wr(d);
      wait_bit(7);
      check(port_data_reg_out, b);
      check(sl_rx, d);
      @(posedge clk_sys_in);
      check({7'h00, irq_out}, {7'h00, irq_en_in});
      check({7'h00, ctl[6]}, 8'h01);
      nss_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
    end
    ctrl_wr(8'h45);
    irq_en_in <= 1'b1;
    nss_in <= 1'b0;
    wait_bit(5);
    check(ctl & 8'hE1, 8'h20);
    @(posedge clk_sys_in);
    check({7'h00, irq_out}, 8'h01);
    nss_in <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    data_wr(8'h3C);
    check(ctl & 8'h43, 8'h02);
    ctrl_wr(8'h45);
    check(ctl, 8'h47);
    load_slave(8'h5A);
    data_wr(8'hC3);
    data_wr(8'h96);
    check({7'h00, ctl[1]}, 8'h00);
    wait_bit(7);
    check(port_data_reg_out, 8'h5A);
    ctrl_wr(8'h45);
    wait_bit(7);
    check(sl_rx, 8'h96);
    check({7'h00, ctl[1]}, 8'h01);
    // a clearing write while the enable is low must be lost
    ce_in <= 1'b0;
    ctrl_wr(8'h00);
    check(ctl, 8'hC7);
    ce_in <= 1'b1;
    @(posedge clk_sys_in);
    give_verdict;
  end
endmodule
